// >>> hw/crf_defines.vh
// Constants for the CPU register file and condition-code block.
`ifndef CRF_DEFINES_VH
`define CRF_DEFINES_VH

// Condition-code bit positions.
`define CRF_CC_MASK 7
`define CRF_CC_USER 6
`define CRF_CC_HALF 5
`define CRF_CC_NEG 3
`define CRF_CC_ZERO 2
`define CRF_CC_OVF 1
`define CRF_CC_CARRY 0

// Condition-code reset value: mask bit set, all other bits clear.
`define CRF_CC_RESET 8'h80

// Access widths on the register port.
`define CRF_W_BYTE 2'h0
`define CRF_W_WORD 2'h1
`define CRF_W_LONG 2'h2

// Condition-code operations of the control-register instructions.
`define CRF_CC_OP_NONE 3'h0
`define CRF_CC_OP_LOAD 3'h1
`define CRF_CC_OP_AND 3'h2
`define CRF_CC_OP_OR 3'h3
`define CRF_CC_OP_XOR 3'h4

// Execution state counts.
`define CRF_ST_ADDSUB 5'h02
`define CRF_ST_MUL8 5'h0e
`define CRF_ST_DIV16 5'h0e
`define CRF_ST_MUL16 5'h16
`define CRF_ST_DIV32 5'h16

// Operation classes for the state timer.
`define CRF_OP_ADDSUB 3'h0
`define CRF_OP_MUL8 3'h1
`define CRF_OP_MUL16 3'h2
`define CRF_OP_DIV16 3'h3
`define CRF_OP_DIV32 3'h4

// Address space and program counter width.
`define CRF_PC_W 24
`define CRF_ADDR_W 16
`define CRF_SP_INDEX 3'h7

`endif

// >>> hw/crf_state_timer.v
// Counts the execution states of a register-to-register operation.
`timescale 1ns/10ps
`default_nettype none
`include "crf_defines.vh"

module crf_state_timer (
    // Clock and reset.
    input wire core_clk,
    input wire rst_n,
    // Start request and operation class.
    input wire start,
    input wire [2:0] op_class,
    // Status.
    output reg busy,
    output reg done
);

    reg [4:0] count_reg;

    // Number of states for each operation class.
    function [4:0] states_of;
        input [2:0] cls;
        begin
            case (cls)
                `CRF_OP_MUL8: states_of = `CRF_ST_MUL8;
                `CRF_OP_MUL16: states_of = `CRF_ST_MUL16;
                `CRF_OP_DIV16: states_of = `CRF_ST_DIV16;
                `CRF_OP_DIV32: states_of = `CRF_ST_DIV32;
                default: states_of = `CRF_ST_ADDSUB;
            endcase
        end
    endfunction

    // Busy for exactly the state count; done pulses in the cycle after the last state.
    // A start while busy is ignored so a running count is never cut short.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 5'h00;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!busy && start) begin
                count_reg <= states_of(op_class);
                busy <= 1'b1;
            end else if (busy) begin
                if (count_reg == 5'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                count_reg <= count_reg - 5'h01;
            end
        end
    end

endmodule
`default_nettype wire

// >>> hw/crf_core.v
// CPU general registers, program counter and condition-code register.
//
// What this block does
// - Eight identical 32-bit general registers.
// - Upper and lower 16-bit halves separately accessible.
// - Lower half splits into high and low bytes.
// - Access width chosen per access, per register.
// - Register seven doubles as stack pointer.
// - 24-bit program counter holds next address.
// - Fetch address forces program counter bit zero.
// - Reset sequence loads vector into program counter.
// - Reset sequence sets mask, other flags untouched.
// - Mask blocks interrupts except non-maskable one.
// - Every exception sequence sets the mask bit.
// - Condition code load, store, AND, OR, XOR.
// - N, Z, V, C drive branch conditions.
// - Mask bit 7, user bit 6, half-carry 5.
// - Register add and subtract take two states.
// - Multiply and divide take 14 or 22 states.
// - Normal mode only, 64-Kbyte address space.
// - Sleep instruction enters power-down state.
// - Half-carry from bits 3, 11 or 27.
// - Zero, negative, overflow, carry flag placement.
`timescale 1ns/10ps
`default_nettype none
`include "crf_defines.vh"

module crf_core #(
    parameter NUM_GPR = 8
) (
    // Clock and reset.
    input wire core_clk,
    input wire rst_n,
    // General register read port A.
    input wire [3:0] rd_a_sel,
    input wire [1:0] rd_a_width,
    output reg [31:0] rd_a_data,
    // General register read port B.
    input wire [3:0] rd_b_sel,
    input wire [1:0] rd_b_width,
    output reg [31:0] rd_b_data,
    // General register write port.
    input wire wr_en,
    input wire [3:0] wr_sel,
    input wire [1:0] wr_width,
    input wire [31:0] wr_data,
    // Stack pointer adjust for calls, returns and exceptions.
    input wire sp_wr_en,
    input wire [31:0] sp_wr_data,
    output reg [31:0] stack_pointer,
    // Program counter control.
    input wire pc_load,
    input wire [23:0] pc_load_value,
    input wire pc_advance,
    output reg [23:0] pc_value,
    output reg [15:0] fetch_addr,
    // Exception sequencing.
    input wire reset_seq,
    input wire [23:0] reset_vector,
    input wire exc_start,
    // Interrupt gating.
    input wire irq_req,
    input wire nmi_req,
    output reg irq_accept,
    output reg nmi_accept,
    // Condition-code control-register instructions.
    input wire [2:0] cc_op,
    input wire [7:0] cc_operand,
    output reg [7:0] condition_code,
    // Flag update from the arithmetic unit.
    input wire alu_flags_en,
    input wire [1:0] alu_width,
    input wire [31:0] alu_result,
    input wire alu_half,
    input wire alu_ovf,
    input wire alu_carry,
    // Branch condition inputs.
    output reg [3:0] branch_flags,
    // Operation timing.
    input wire op_start,
    input wire [2:0] op_class,
    output reg op_busy,
    output reg op_done,
    // Power-down.
    input wire sleep_exec,
    input wire wake,
    output reg power_down
);

    // General register array.
    // No reset on the array: general registers start out undefined.
    reg [31:0] gpr32 [0:NUM_GPR-1];
    reg [23:0] pc_reg;
    reg [7:0] condition_code_reg;
    reg power_down_reg;
    wire timer_busy;
    wire timer_done;
    integer i;

    // Selector layout: bit 3 picks the half or byte, bits 2..0 the register.
    // For word access bit 3 set means the upper extended half.
    // For byte access bit 3 set means the low byte, clear the high byte.
    function [31:0] view_read;
        input [31:0] full;
        input [1:0] width;
        input sel_hi;
        begin
            case (width)
                `CRF_W_LONG: view_read = full;
                `CRF_W_WORD: view_read = sel_hi ?
                    {16'h0000, full[31:16]} :
                    {16'h0000, full[15:0]};
                `CRF_W_BYTE: view_read = sel_hi ?
                    {24'h000000, full[7:0]} :
                    {24'h000000, full[15:8]};
                default: view_read = full;
            endcase
        end
    endfunction

    // Merge a narrow write into the full register value.
    // Narrow data always arrives in the low bits of the write data.
    function [31:0] view_write;
        input [31:0] full;
        input [1:0] width;
        input sel_hi;
        input [31:0] data;
        begin
            case (width)
                `CRF_W_LONG: view_write = data;
                `CRF_W_WORD: view_write = sel_hi ?
                    {data[15:0], full[15:0]} :
                    {full[31:16], data[15:0]};
                `CRF_W_BYTE: view_write = sel_hi ?
                    {full[31:8], data[7:0]} :
                    {full[31:16], data[7:0], full[7:0]};
                default: view_write = full;
            endcase
        end
    endfunction

    // Significant-bit mask for flag evaluation at a given width.
    // Zero is judged only on the bits of the operation width, since the
    // arithmetic unit may leave junk above them.
    function [31:0] width_mask;
        input [1:0] width;
        begin
            case (width)
                `CRF_W_BYTE: width_mask = 32'h000000ff;
                `CRF_W_WORD: width_mask = 32'h0000ffff;
                default: width_mask = 32'hffffffff;
            endcase
        end
    endfunction

    // Sign bit of a result at the given width.
    // The negative flag follows the top bit of the active width.
    function sign_of;
        input [31:0] value;
        input [1:0] width;
        begin
            case (width)
                `CRF_W_BYTE: sign_of = value[7];
                `CRF_W_WORD: sign_of = value[15];
                default: sign_of = value[31];
            endcase
        end
    endfunction

    // Registers are written with whichever width the instruction uses;
    // each register is independent, so mixed views never interfere.
    // Register contents have no defined reset value, as in the CPU.
    // When an instruction writes register seven in the same cycle as a
    // stack adjust, the instruction wins and the adjust is dropped, so
    // the decoder must not issue both at once.
    always @(posedge core_clk) begin
        for (i = 0; i < NUM_GPR; i = i + 1) begin
            if (wr_en && wr_sel[2:0] == i[2:0]) begin
                gpr32[i] <= view_write(gpr32[i], wr_width, wr_sel[3],
                    wr_data);
            end else if (sp_wr_en && i[2:0] == `CRF_SP_INDEX) begin
                gpr32[i] <= sp_wr_data;
            end
        end
    end

    // Registered read ports and stack pointer view.
    // Reads see the value before any write of the same cycle, so a write
    // shows on the read data two edges later. The extra cycle buys outputs
    // that come straight from flops.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_a_data <= 32'h00000000;
            rd_b_data <= 32'h00000000;
            stack_pointer <= 32'h00000000;
        end else begin
            rd_a_data <= view_read(gpr32[rd_a_sel[2:0]], rd_a_width,
                rd_a_sel[3]);
            rd_b_data <= view_read(gpr32[rd_b_sel[2:0]], rd_b_width,
                rd_b_sel[3]);
            stack_pointer <= gpr32[`CRF_SP_INDEX];
        end
    end

    // Program counter: the reset vector wins over any other load.
    // The counter steps by a whole instruction word, so bit zero only
    // changes through a load or the reset vector.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_reg <= 24'h000000;
        end else if (reset_seq) begin
            pc_reg <= reset_vector;
        end else if (pc_load) begin
            pc_reg <= pc_load_value;
        end else if (pc_advance) begin
            pc_reg <= pc_reg + 24'h000002;
        end
    end

    // Program counter outputs. Only the low 16 bits address memory since
    // the device runs in normal mode; bit zero is forced low on fetch.
    // The upper counter bits are still kept for the full 24-bit view.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_value <= 24'h000000;
            fetch_addr <= 16'h0000;
        end else begin
            pc_value <= pc_reg;
            fetch_addr <= {pc_reg[15:1], 1'b0};
        end
    end

    // Condition code. Reset and exception entry set the mask and leave the
    // other bits alone; the async reset gives a defined value so the mask
    // is high even before the reset sequence runs.
    // Control-register instructions outrank arithmetic so that a flag
    // update in the same cycle cannot undo an explicit load.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            condition_code_reg <= `CRF_CC_RESET;
        end else if (reset_seq || exc_start) begin
            condition_code_reg[`CRF_CC_MASK] <= 1'b1;
        end else if (cc_op != `CRF_CC_OP_NONE) begin
            case (cc_op)
                `CRF_CC_OP_LOAD: condition_code_reg <= cc_operand;
                `CRF_CC_OP_AND: condition_code_reg <=
                    condition_code_reg & cc_operand;
                `CRF_CC_OP_OR: condition_code_reg <=
                    condition_code_reg | cc_operand;
                `CRF_CC_OP_XOR: condition_code_reg <=
                    condition_code_reg ^ cc_operand;
                default: condition_code_reg <= condition_code_reg;
            endcase
        end else if (alu_flags_en) begin
            // The user bit and mask are never touched by arithmetic.
            condition_code_reg[`CRF_CC_HALF] <= alu_half;
            condition_code_reg[`CRF_CC_NEG] <=
                sign_of(alu_result, alu_width);
            condition_code_reg[`CRF_CC_ZERO] <=
                (alu_result & width_mask(alu_width)) == 32'h00000000;
            condition_code_reg[`CRF_CC_OVF] <= alu_ovf;
            condition_code_reg[`CRF_CC_CARRY] <= alu_carry;
        end
    end

    // Condition-code and branch flag outputs.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            condition_code <= `CRF_CC_RESET;
            branch_flags <= 4'h0;
        end else begin
            condition_code <= condition_code_reg;
            branch_flags <= {condition_code_reg[`CRF_CC_NEG],
                condition_code_reg[`CRF_CC_ZERO],
                condition_code_reg[`CRF_CC_OVF],
                condition_code_reg[`CRF_CC_CARRY]};
        end
    end

    // Interrupt gating: a set mask blocks ordinary requests but never the
    // non-maskable one.
    // The ordinary request is dropped in a cycle with a non-maskable one
    // so that only one acceptance is raised at a time.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_accept <= 1'b0;
            nmi_accept <= 1'b0;
        end else begin
            irq_accept <= irq_req && !condition_code_reg[`CRF_CC_MASK] &&
                !nmi_req;
            nmi_accept <= nmi_req;
        end
    end

    // Sleep puts the core into power-down until a wake event.
    // Wake outranks sleep, so a wake that arrives together with the sleep
    // instruction leaves the core running.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_down_reg <= 1'b0;
        end else if (wake) begin
            power_down_reg <= 1'b0;
        end else if (sleep_exec) begin
            power_down_reg <= 1'b1;
        end
    end

    // Power-down output.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_down <= 1'b0;
        end else begin
            power_down <= power_down_reg;
        end
    end

    // Operation state timer; outputs re-registered to keep them on flops.
    // A start while the timer runs is ignored, so the decoder must wait
    // for done before it issues the next timed operation.
    crf_state_timer u_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(op_start),
        .op_class(op_class),
        .busy(timer_busy),
        .done(timer_done)
    );

    // Timer status outputs, one cycle behind the timer itself.
    // Busy therefore first shows at the second edge after the start, and
    // done follows the last busy cycle.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_busy <= 1'b0;
            op_done <= 1'b0;
        end else begin
            op_busy <= timer_busy;
            op_done <= timer_done;
        end
    end

endmodule
`default_nettype wire

// >>> test/crf_core_properties.sv
// Concurrent checks on the register and condition-code block ports.
`timescale 1ns/10ps
`default_nettype none
`include "crf_defines.vh"
module crf_core_properties (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Program counter and exception controls.
    input wire logic pc_load,
    input wire logic pc_advance,
    input wire logic reset_seq,
    input wire logic [23:0] reset_vector,
    input wire logic [23:0] pc_value,
    input wire logic [15:0] fetch_addr,
    input wire logic exc_start,
    // Interrupt gating.
    input wire logic irq_req,
    input wire logic nmi_req,
    input wire logic irq_accept,
    input wire logic nmi_accept,
    // Condition code and branch inputs.
    input wire logic [7:0] condition_code,
    input wire logic [3:0] branch_flags,
    // Timing and power-down.
    input wire logic op_start,
    input wire logic [2:0] op_class,
    input wire logic op_busy,
    input wire logic op_done,
    input wire logic sleep_exec,
    input wire logic wake,
    input wire logic power_down
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // A start taken while idle, then the two busy states and the pulse.
    sequence s_addsub_go;
        op_start && op_class == `CRF_OP_ADDSUB ##1 !op_busy;
    endsequence
    sequence s_addsub_run;
        op_busy [*2] ##1 (op_done && !op_busy);
    endsequence

    chk_nmi_taken: assert property (nmi_req |=> nmi_accept)
        else $error("nmi request not accepted");
    chk_irq_gate: assert property (irq_accept |-> $past(irq_req) &&
        !$past(nmi_req) && !condition_code[`CRF_CC_MASK])
        else $error("irq accepted while masked or unrequested");
    chk_exc_mask: assert property (exc_start |-> ##2 condition_code[7])
        else $error("exception start left mask clear");
    chk_reset_vec: assert property (reset_seq |-> ##2
        pc_value == $past(reset_vector, 2) && condition_code[7])
        else $error("reset sequence did not load vector and mask");
    chk_fetch_even: assert property (fetch_addr ==
        {pc_value[15:1], 1'b0})
        else $error("fetch address not even copy of pc");
    chk_pc_step: assert property (pc_advance && !pc_load && !reset_seq
        |=> ##1 pc_value == $past(pc_value) + 24'h2)
        else $error("pc did not advance by two");
    chk_addsub_len: assert property (s_addsub_go |=> s_addsub_run)
        else $error("add or subtract not two states");
    chk_done_once: assert property (op_done |->
        $past(op_busy) && !op_busy ##1 !op_done)
        else $error("done pulse misplaced");
    chk_branch_flags: assert property (branch_flags ==
        condition_code[3:0])
        else $error("branch flags differ from condition code");
    chk_sleep_entry: assert property (sleep_exec && !wake
        |-> ##2 power_down)
        else $error("sleep did not enter power-down");
endmodule
bind crf_core crf_core_properties u_props (.*);
`default_nettype wire

// >>> test/crf_exec_model.sv
// Arithmetic-unit stand-in that feeds add results and flags to the block.
`timescale 1ns/10ps
`default_nettype none
`include "crf_defines.vh"
module crf_exec_model (
    // Request from the bench.
    input wire logic go,
    input wire logic [1:0] width,
    input wire logic [31:0] a,
    input wire logic [31:0] b,
    // Flag update towards the block.
    output logic flags_en,
    output logic [31:0] result,
    output logic half,
    output logic ovf,
    output logic carry
);
    logic [32:0] mask, hmask, sum, hsum;
    logic [5:0] msb;
    // Adds at the chosen width; half-carry is the carry into the top nibble.
    always_comb begin
        msb = (width == `CRF_W_BYTE) ? 6'h07 :
            (width == `CRF_W_WORD) ? 6'h0f : 6'h1f;
        mask = (33'h1 << (msb + 6'h01)) - 33'h1;
        hmask = (33'h1 << (msb - 6'h03)) - 33'h1;
        sum = ({1'b0, a} & mask) + ({1'b0, b} & mask);
        hsum = ({1'b0, a} & hmask) + ({1'b0, b} & hmask);
        result = sum[31:0] & mask[31:0];
        carry = sum[msb + 6'h01];
        half = hsum[msb - 6'h03];
        ovf = (a[msb] == b[msb]) && (sum[msb] != a[msb]);
        flags_en = go;
    end
endmodule
`default_nettype wire

// >>> test/crf_core_bench.sv
// Self-checking bench for the register and condition-code block.
`timescale 1ns/10ps
`default_nettype none
`include "crf_defines.vh"
module crf_core_bench;
    logic core_clk, rst_n, wr_en, sp_wr_en, pc_load, pc_advance, reset_seq;
    logic exc_start, irq_req, nmi_req, go, op_start, sleep_exec, wake;
    logic alu_flags_en, alu_half, alu_ovf, alu_carry, irq_accept;
    logic nmi_accept, op_busy, op_done, power_down;
    logic [3:0] rd_a_sel, rd_b_sel, wr_sel, branch_flags;
    logic [1:0] rd_a_width, rd_b_width, wr_width, alu_width;
    logic [31:0] wr_data, sp_wr_data, alu_result, rd_a_data, rd_b_data;
    logic [31:0] stack_pointer, op_a, op_b;
    logic [23:0] pc_load_value, reset_vector, pc_value;
    logic [15:0] fetch_addr;
    logic [2:0] cc_op, op_class;
    logic [7:0] cc_operand, condition_code;
    int err_total, check_count;

    crf_core u_dut (.*);
    crf_exec_model u_exec (.go(go), .width(alu_width), .a(op_a), .b(op_b),
        .flags_en(alu_flags_en), .result(alu_result), .half(alu_half),
        .ovf(alu_ovf), .carry(alu_carry));

    // Free-running core clock.
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] seen, exp, input string what);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude;
        $display("Checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Outputs are registered twice behind a request, so wait two edges.
    task automatic settle;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] s, input logic [1:0] w,
        input logic [31:0] d);
        @(posedge core_clk);
        wr_en <= 1'b1;
        wr_sel <= s;
        wr_width <= w;
        wr_data <= d;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] s, input logic [1:0] w,
        input logic [31:0] exp);
        @(posedge core_clk);
        rd_a_sel <= s;
        rd_a_width <= w;
        rd_b_sel <= s;
        rd_b_width <= w;
        settle;
        check(rd_a_data, exp, "rd_a_data");
        check(rd_b_data, exp, "rd_b_data");
    endtask

    task automatic ccop(input logic [2:0] op, input logic [7:0] v);
        @(posedge core_clk);
        cc_op <= op;
        cc_operand <= v;
        @(posedge core_clk);
        cc_op <= `CRF_CC_OP_NONE;
        settle;
    endtask

    task automatic t_regs;
        for (int i = 0; i < 8; i++)
            wr({1'b0, i[2:0]}, `CRF_W_LONG, 32'h11111111 * (i + 1));
        for (int i = 0; i < 8; i++)
            rd({1'b0, i[2:0]}, `CRF_W_LONG, 32'h11111111 * (i + 1));
        wr(4'ha, `CRF_W_WORD, 32'h0000abcd);
        wr(4'h2, `CRF_W_BYTE, 32'h000000ef);
        wr(4'ha, `CRF_W_BYTE, 32'h00000012);
        rd(4'h2, `CRF_W_LONG, 32'habcdef12);
        rd(4'ha, `CRF_W_WORD, 32'h0000abcd);
        rd(4'h2, `CRF_W_WORD, 32'h0000ef12);
        rd(4'h2, `CRF_W_BYTE, 32'h000000ef);
        rd(4'ha, `CRF_W_BYTE, 32'h00000012);
        rd(4'h3, `CRF_W_LONG, 32'h44444444);
        @(posedge core_clk);
        sp_wr_en <= 1'b1;
        sp_wr_data <= 32'h0000fffe;
        @(posedge core_clk);
        sp_wr_en <= 1'b0;
        settle;
        check(stack_pointer, 32'h0000fffe, "stack_pointer");
        wr(4'h7, `CRF_W_LONG, 32'h00001000);
        rd(4'h7, `CRF_W_LONG, 32'h00001000);
        check(stack_pointer, 32'h00001000, "stack_pointer");
        $display("t_regs done");
    endtask

    task automatic t_pc_cc;
        logic [2:0] ops [3] = '{`CRF_CC_OP_AND, `CRF_CC_OP_OR, `CRF_CC_OP_XOR};
        logic [7:0] arg [3] = '{8'h3c, 8'h41, 8'hff};
        logic [7:0] exp [3] = '{8'hbc, 8'hfd, 8'h02};
        ccop(`CRF_CC_OP_LOAD, 8'h7f);
        check(condition_code, 8'h7f, "condition_code");
        for (int i = 0; i < 3; i++) begin
            ccop(ops[i], arg[i]);
            if (i == 0) begin
                @(posedge core_clk);
                exc_start <= 1'b1;
                @(posedge core_clk);
                exc_start <= 1'b0;
                settle;
            end
            check(condition_code, exp[i], "condition_code");
            check(branch_flags, exp[i][3:0], "branch_flags");
        end
        ccop(`CRF_CC_OP_LOAD, 8'h15);
        @(posedge core_clk);
        reset_seq <= 1'b1;
        reset_vector <= 24'h123457;
        @(posedge core_clk);
        reset_seq <= 1'b0;
        settle;
        check(condition_code, 8'h95, "condition_code");
        check(pc_value, 24'h123457, "pc_value");
        check(fetch_addr, 16'h3456, "fetch_addr");
        @(posedge core_clk);
        pc_advance <= 1'b1;
        @(posedge core_clk);
        pc_advance <= 1'b0;
        settle;
        check(pc_value, 24'h123459, "pc_value");
        check(fetch_addr, 16'h3458, "fetch_addr");
        @(posedge core_clk);
        pc_load <= 1'b1;
        pc_load_value <= 24'h00beef;
        @(posedge core_clk);
        pc_load <= 1'b0;
        settle;
        check(pc_value, 24'h00beef, "pc_value");
        check(fetch_addr, 16'hbeee, "fetch_addr");
        $display("t_pc_cc done");
    endtask

    task automatic t_irq;
        ccop(`CRF_CC_OP_LOAD, 8'h00);
        @(posedge core_clk);
        irq_req <= 1'b1;
        settle;
        check(irq_accept, 1'b1, "irq_accept");
        @(posedge core_clk);
        nmi_req <= 1'b1;
        settle;
        check(nmi_accept, 1'b1, "nmi_accept");
        check(irq_accept, 1'b0, "irq_accept");
        ccop(`CRF_CC_OP_LOAD, 8'h80);
        check(nmi_accept, 1'b1, "nmi_accept");
        @(posedge core_clk);
        nmi_req <= 1'b0;
        settle;
        check(irq_accept, 1'b0, "irq_accept");
        @(posedge core_clk);
        irq_req <= 1'b0;
        $display("t_irq done");
    endtask

    task automatic t_alu;
        logic [1:0] w [4] = '{`CRF_W_BYTE, `CRF_W_BYTE, `CRF_W_WORD,
            `CRF_W_LONG};
        logic [31:0] a [4] = '{32'h0f, 32'h80, 32'h0fff, 32'h7fffffff};
        logic [31:0] b [4] = '{32'h01, 32'h80, 32'h0001, 32'h00000001};
        logic [7:0] exp [4] = '{8'he0, 8'hc7, 8'he0, 8'hea};
        ccop(`CRF_CC_OP_LOAD, 8'hc0);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            go <= 1'b1;
            alu_width <= w[i];
            op_a <= a[i];
            op_b <= b[i];
            @(posedge core_clk);
            go <= 1'b0;
            settle;
            check(condition_code, exp[i], "condition_code");
        end
        $display("t_alu done");
    endtask

    task automatic t_timer;
        logic [4:0] lens [6] = '{`CRF_ST_ADDSUB, `CRF_ST_MUL8, `CRF_ST_MUL16,
            `CRF_ST_DIV16, `CRF_ST_DIV32, `CRF_ST_ADDSUB};
        int n, k;
        for (int c = 0; c < 6; c++) begin
            @(posedge core_clk);
            op_start <= 1'b1;
            op_class <= c[2:0];
            @(posedge core_clk);
            op_start <= 1'b0;
            n = 0;
            for (k = 0; k < 40 && op_done !== 1'b1; k++) begin
                @(posedge core_clk);
                #1;
                if (op_busy === 1'b1)
                    n++;
            end
            if (k == 40) begin
                err_total++;
                conclude;
            end
            check(n, lens[c], "op_busy length");
        end
        $display("t_timer done");
    endtask

    task automatic t_sleep;
        @(posedge core_clk);
        sleep_exec <= 1'b1;
        @(posedge core_clk);
        sleep_exec <= 1'b0;
        settle;
        check(power_down, 1'b1, "power_down");
        @(posedge core_clk);
        wake <= 1'b1;
        @(posedge core_clk);
        wake <= 1'b0;
        settle;
        check(power_down, 1'b0, "power_down");
        $display("t_sleep done");
    endtask

    // Main sequence: reset for two cycles, then each scenario in turn.
    initial begin
        {rst_n, wr_en, sp_wr_en, pc_load, pc_advance, reset_seq, exc_start,
            irq_req, nmi_req, go, op_start, sleep_exec, wake} = '0;
        {rd_a_sel, rd_b_sel, wr_sel, rd_a_width, rd_b_width, wr_width,
            alu_width, wr_data, sp_wr_data, op_a, op_b, pc_load_value,
            reset_vector, cc_op, op_class, cc_operand} = '0;
        err_total = 0;
        check_count = 0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        check(condition_code, 8'h80, "condition_code");
        t_regs;
        t_pc_cc;
        t_irq;
        t_alu;
        t_timer;
        t_sleep;
        conclude;
    end
endmodule
`default_nettype wire
